// ---- include/pepc_pkg.sv ----
// shared constants and carrier types of the port end-to-end parity block
// assumes a 32-bit axi4-lite register bus and one 32-bit double word per beat
package pepc_pkg;

   // bus and data widths
   localparam int DW_W   = 32;            // double word width
   localparam int PAR_W  = 4;             // one even parity bit per byte
   localparam int ADDR_W = 12;            // register byte address width
   localparam int LEN_W  = 8;             // header length byte width
   localparam int REP_W  = 2;             // reporting field width
   localparam int CNT_W  = 8;             // error tally width
   localparam int IRQ_W  = 2;             // interrupt event bits

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 12'h740; // parity_error_control
   localparam logic [ADDR_W-1:0] OFF_STAT     = 12'h744; // error status, write one to clear
   localparam logic [ADDR_W-1:0] OFF_REPCTL   = 12'h748; // reporting control
   localparam logic [ADDR_W-1:0] OFF_TALLY    = 12'h74c; // error tally, clear on read
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h760; // sticky event bits, read only
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 12'h764; // event enables
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 12'h768; // write one to clear events

   // field positions
   localparam int CTRL_DIS_BIT  = 0;      // parity_check_disable
   localparam int CTRL_INJ_BIT  = 1;      // bad_parity_inject
   localparam int CTRL_LEN_LSB  = 8;      // match length field, bits 15:8
   localparam int STAT_ERR_BIT  = 0;      // end_to_end_parity_error
   localparam int HDR_LEN_LSB   = 24;     // header byte zero sits in data[31:24]
   localparam int IRQ_PERR_BIT  = 0;      // parity error event
   localparam int IRQ_SAT_BIT   = 1;      // tally saturated event

   // reset value and tally ceiling
   localparam logic [REP_W-1:0] REP_RST = 2'h2;   // nonfatal by default
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;  // tally ceiling

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // reporting message kinds
   typedef enum logic [REP_W-1:0] {
      SEV_NONE     = 2'b00,
      SEV_CORR     = 2'b01,
      SEV_NONFATAL = 2'b10,
      SEV_FATAL    = 2'b11
   } pepc_sev_t;

   // which source owns the path to the core
   typedef enum logic {
      SRC_LINK = 1'b0,
      SRC_GEN  = 1'b1
   } pepc_src_t;

   // one double word beat with its parity and framing
   typedef struct packed {
      logic [DW_W-1:0]  data;
      logic [PAR_W-1:0] par;
      logic             sop;
      logic             eop;
   } pepc_dw_t;

   // complete state of the top module
   typedef struct packed {
      logic                parity_check_disable;    // sticky
      logic                bad_parity_inject;       // sticky
      logic [LEN_W-1:0]    match_len;               // sticky
      logic [CNT_W-1:0]    parity_error_tally;      // sticky
      logic                end_to_end_parity_error;
      logic [REP_W-1:0]    rep_sev;
      logic [IRQ_W-1:0]    irq_stat;
      logic [IRQ_W-1:0]    irq_en;
      logic                irq_out;
      logic                aw_have;
      logic [ADDR_W-1:0]   aw_addr;
      logic                w_have;
      logic [DW_W-1:0]     w_data;
      logic [3:0]          w_strb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [DW_W-1:0]     rdata;
      logic [1:0]          rresp;
      logic                out_valid;
      pepc_dw_t            out_dw;
      logic                lock;
      pepc_src_t           cur_src;
      logic                pkt_hit;
      logic                msg_valid;
      logic [REP_W-1:0]    msg_sev;
   } pepc_state_t;

endpackage

// ---- src/pepc_dw_parity.sv ----
// per-byte even parity generator and checker for one double word
// assumes purely combinational use; the caller registers the results
`timescale 1ns/1ps
module pepc_dw_parity #(
   parameter int DATA_W = 32,
   parameter int PAR_W  = DATA_W / 8
) (
   input  wire logic [DATA_W-1:0] data,
   input  wire logic [PAR_W-1:0]  par_in,
   input  wire logic              check_en,
   input  wire logic              corrupt,
   output logic      [PAR_W-1:0]  par_out,
   output logic                   par_err
);

   logic [PAR_W-1:0] par_calc;   // correct parity of data

   // xor of each byte, so byte plus bit holds an even count of ones
   function automatic logic [PAR_W-1:0] byte_parity(input logic [DATA_W-1:0] d);
      logic [PAR_W-1:0] p;
      p = '0;
      for (int i = 0; i < PAR_W; i++) begin
         p[i] = ^d[i*8 +: 8];
      end
      return p;
   endfunction

   // generation is never gated off
   assign par_calc = byte_parity(data);
   // inverting every bit guarantees a mismatch downstream
   assign par_out  = corrupt ? ~par_calc : par_calc;
   // compare only when the caller asks
   assign par_err  = check_en && (par_in != par_calc);

endmodule

// ---- src/pepc_top.sv ----
// port end-to-end parity: forwards link and originated packets to the core
// assumes synchronous inputs on aclk and an axi4-lite master on the bus
//
// Overview of operation
// - disable bit skips checks, no errors raised
// - parity always generated toward the core
// - inject bit corrupts every dword of matching packets
// - corruption covers link and originated packets alike
// - match field compared with header byte zero
// - sticky error flag, cleared by writing one
// - flag rising sends message of programmed kind
// - tally counts errors, saturates, clears on read
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module pepc_top (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic                       sticky_resetn,
   // axi4-lite slave
   input  wire logic [pepc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [pepc_pkg::DW_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [pepc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [pepc_pkg::DW_W-1:0]       s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // ingress link stream, parity arrives with the data
   input  wire pepc_pkg::pepc_dw_t         link_dw,
   input  wire logic                       link_valid,
   output logic                            link_ready,
   // packets the port originates, parity field unused
   input  wire pepc_pkg::pepc_dw_t         gen_dw,
   input  wire logic                       gen_valid,
   output logic                            gen_ready,
   // toward the switch core
   output pepc_pkg::pepc_dw_t              core_dw,
   output logic                            core_valid,
   input  wire logic                       core_ready,
   // error message request and interrupt
   output logic                            err_msg_valid,
   output pepc_pkg::pepc_sev_t             err_msg_sev,
   output logic                            irq
);
   import pepc_pkg::*;

   pepc_state_t      st_reg;      // all state
   pepc_state_t      st_next;     // its next value
   pepc_src_t        sel_src;     // source owning the path this cycle
   pepc_dw_t         sel_dw;      // beat offered by that source
   logic             sel_valid;   // its valid
   logic             slot_free;   // output stage can load
   logic             take;        // beat accepted this cycle
   logic             hdr_hit;     // header byte matches programmed length
   logic             cur_hit;     // this beat belongs to a matching packet
   logic             corrupt;     // invert parity on this beat
   logic             check_en;    // compare incoming parity on this beat
   logic [PAR_W-1:0] par_gen;     // parity sent to the core
   logic             par_err;     // parity mismatch seen
   logic             wr_fire;     // register write performed
   logic             rd_fire;     // register read performed
   logic [ADDR_W-1:0] wr_addr;    // word aligned write address
   logic [ADDR_W-1:0] rd_addr;    // word aligned read address

   // merge a write into a register honouring byte strobes
   function automatic logic [DW_W-1:0] strb_merge(input logic [DW_W-1:0] old_v,
                                                  input logic [DW_W-1:0] new_v,
                                                  input logic [3:0]      strb);
      logic [DW_W-1:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // word align a byte address
   function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
      return {a[ADDR_W-1:2], 2'b00};
   endfunction

   // packet level arbitration: a started packet keeps the path until eop
   always_comb begin
      if (st_reg.lock) begin
         sel_src = st_reg.cur_src;
      end else if (link_valid) begin
         sel_src = SRC_LINK;      // link first, it cannot be back-pressured for long
      end else begin
         sel_src = SRC_GEN;
      end
      sel_dw    = (sel_src == SRC_LINK) ? link_dw : gen_dw;
      sel_valid = (sel_src == SRC_LINK) ? link_valid : gen_valid;
   end

   // one output register, loaded whenever it empties or drains
   assign slot_free  = !st_reg.out_valid || core_ready;
   assign take       = sel_valid && slot_free;
   assign link_ready = slot_free && (sel_src == SRC_LINK);
   assign gen_ready  = slot_free && (sel_src == SRC_GEN);

   // length match decided on header beat, held for the rest of the packet
   assign hdr_hit  = sel_dw.data[HDR_LEN_LSB +: LEN_W] == st_reg.match_len;
   assign cur_hit  = sel_dw.sop ? hdr_hit : st_reg.pkt_hit;
   // either source may be corrupted, no source term here
   assign corrupt  = st_reg.bad_parity_inject && cur_hit;
   // only link beats carry parity to check; disable blocks every error
   assign check_en = take && (sel_src == SRC_LINK) && !st_reg.parity_check_disable;

   // parity generation and check on the selected beat
   pepc_dw_parity #(
      .DATA_W (DW_W),
      .PAR_W  (PAR_W)
   ) u_parity (
      .data     (sel_dw.data),
      .par_in   (sel_dw.par),
      .check_en (check_en),
      .corrupt  (corrupt),
      .par_out  (par_gen),
      .par_err  (par_err)
   );

   // bus handshakes straight from state
   assign s_axi_awready = !st_reg.aw_have;
   assign s_axi_wready  = !st_reg.w_have;
   assign s_axi_arready = !st_reg.rvalid;
   assign wr_fire       = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
   assign rd_fire       = s_axi_arvalid && !st_reg.rvalid;
   assign wr_addr       = word_addr(st_reg.aw_addr);
   assign rd_addr       = word_addr(s_axi_araddr);

   // next state of everything
   always_comb begin
      logic [DW_W-1:0]  ctrl_w;     // control register after a write
      logic [CNT_W-1:0] tally_base; // tally after a clearing read
      logic             sat_evt;    // error arrived with tally full
      logic             rd_ok;      // read address mapped
      logic             wr_ok;      // write address mapped
      ctrl_w     = '0;
      tally_base = '0;
      sat_evt    = 1'b0;
      rd_ok      = 1'b1;
      wr_ok      = 1'b1;
      st_next    = st_reg;
      st_next.msg_valid = 1'b0;

      // address channel capture, held until the write is done
      if (s_axi_awvalid && !st_reg.aw_have) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      // data channel capture, either order
      if (s_axi_wvalid && !st_reg.w_have) begin
         st_next.w_have = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      // response drains
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // write decode
      if (wr_fire) begin
         st_next.aw_have = 1'b0;
         st_next.w_have  = 1'b0;
         st_next.bvalid  = 1'b1;
         unique case (wr_addr)
            OFF_CTRL: begin
               ctrl_w = strb_merge({16'h0, st_reg.match_len, 6'h0,
                                    st_reg.bad_parity_inject, st_reg.parity_check_disable},
                                   st_reg.w_data, st_reg.w_strb);
               st_next.parity_check_disable = ctrl_w[CTRL_DIS_BIT];
               st_next.bad_parity_inject    = ctrl_w[CTRL_INJ_BIT];
               st_next.match_len            = ctrl_w[CTRL_LEN_LSB +: LEN_W];
            end
            OFF_STAT: begin
               // write one clears; a new error below sets it back
               if (st_reg.w_strb[0] && st_reg.w_data[STAT_ERR_BIT]) begin
                  st_next.end_to_end_parity_error = 1'b0;
               end
            end
            OFF_REPCTL: begin
               if (st_reg.w_strb[0]) begin
                  st_next.rep_sev = st_reg.w_data[REP_W-1:0];
               end
            end
            OFF_IRQ_EN: begin
               if (st_reg.w_strb[0]) begin
                  st_next.irq_en = st_reg.w_data[IRQ_W-1:0];
               end
            end
            OFF_IRQ_CLR: begin
               if (st_reg.w_strb[0]) begin
                  st_next.irq_stat = st_reg.irq_stat & ~st_reg.w_data[IRQ_W-1:0];
               end
            end
            // tally and event status ignore writes
            OFF_TALLY, OFF_IRQ_STAT: begin
               wr_ok = 1'b1;
            end
            default: begin
               wr_ok = 1'b0;
            end
         endcase
         st_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end

      // read response drains
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      // read decode, registered one cycle after the address is taken
      if (rd_fire) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = '0;
         unique case (rd_addr)
            OFF_CTRL: begin
               st_next.rdata[CTRL_DIS_BIT]             = st_reg.parity_check_disable;
               st_next.rdata[CTRL_INJ_BIT]             = st_reg.bad_parity_inject;
               st_next.rdata[CTRL_LEN_LSB +: LEN_W]    = st_reg.match_len;
            end
            OFF_STAT:     st_next.rdata[STAT_ERR_BIT]  = st_reg.end_to_end_parity_error;
            OFF_REPCTL:   st_next.rdata[REP_W-1:0]     = st_reg.rep_sev;
            OFF_TALLY:    st_next.rdata[CNT_W-1:0]     = st_reg.parity_error_tally;
            OFF_IRQ_STAT: st_next.rdata[IRQ_W-1:0]     = st_reg.irq_stat;
            OFF_IRQ_EN:   st_next.rdata[IRQ_W-1:0]     = st_reg.irq_en;
            // clear register is write only
            OFF_IRQ_CLR:  rd_ok = 1'b1;
            default:      rd_ok = 1'b0;
         endcase
         st_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end

      // tally: a read clears first, then an error in the same cycle counts
      tally_base = (rd_fire && rd_addr == OFF_TALLY) ? '0 : st_reg.parity_error_tally;
      st_next.parity_error_tally = tally_base;
      if (par_err) begin
         if (tally_base == CNT_MAX) begin
            sat_evt = 1'b1;                                  // holds, no wrap
         end else begin
            st_next.parity_error_tally = tally_base + 8'h01;
         end
      end

      // error flag: set wins over a simultaneous clear
      if (par_err) begin
         st_next.end_to_end_parity_error = 1'b1;
         // message only on a zero to one change of the flag
         if (!st_reg.end_to_end_parity_error && st_reg.rep_sev != SEV_NONE) begin
            st_next.msg_valid = 1'b1;
            st_next.msg_sev   = st_reg.rep_sev;
         end
      end

      // sticky event bits, set wins over clear
      st_next.irq_stat[IRQ_PERR_BIT] = st_next.irq_stat[IRQ_PERR_BIT] | par_err;
      st_next.irq_stat[IRQ_SAT_BIT]  = st_next.irq_stat[IRQ_SAT_BIT] | sat_evt;
      st_next.irq_out = |(st_next.irq_stat & st_next.irq_en);

      // output stage
      if (take) begin
         st_next.out_valid = 1'b1;
         st_next.out_dw    = '{data: sel_dw.data, par: par_gen, sop: sel_dw.sop, eop: sel_dw.eop};
         st_next.lock      = !sel_dw.eop;
         st_next.cur_src   = sel_src;
         if (sel_dw.sop) begin
            st_next.pkt_hit = hdr_hit;
         end
      end else if (core_ready) begin
         st_next.out_valid = 1'b0;
      end
   end

   // register the state; control fields and tally survive a plain reset, reporting kind and event enables do not
   always_ff @(posedge aclk) begin
      if (!sticky_resetn) begin
         st_reg         <= '0;
         st_reg.rep_sev <= REP_RST;
      end else if (!aresetn) begin
         st_reg                      <= '0;
         st_reg.rep_sev              <= REP_RST;
         // sticky fields keep their value
         st_reg.parity_check_disable <= st_reg.parity_check_disable;
         st_reg.bad_parity_inject    <= st_reg.bad_parity_inject;
         st_reg.match_len            <= st_reg.match_len;
         st_reg.parity_error_tally   <= st_reg.parity_error_tally;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs from flip-flops
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rdata   = st_reg.rdata;
   assign s_axi_rresp   = st_reg.rresp;
   assign core_valid    = st_reg.out_valid;
   assign core_dw       = st_reg.out_dw;
   assign err_msg_valid = st_reg.msg_valid;
   assign err_msg_sev   = pepc_sev_t'(st_reg.msg_sev);
   assign irq           = st_reg.irq_out;

endmodule

// ---- verification/pepc_core_model.sv ----
// switch core stand-in: takes beats from the port and queues them
// assumes core_dw follows valid/ready and the bench pops the queue
`timescale 1ns/1ps
module pepc_core_model (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire pepc_pkg::pepc_dw_t core_dw,
   input  wire logic              core_valid,
   output logic                   core_ready,
   input  wire logic              slow
);
   import pepc_pkg::*;
   pepc_dw_t got[$];   // beats seen, oldest first
   logic     tog;      // stall phase when slow
   // slow mode refuses every other cycle so the port must hold its beat
   always @(posedge aclk) begin
      if (!aresetn) begin
         tog <= 1'b0;
      end else begin
         tog <= ~tog;
         if (core_valid && core_ready) got.push_back(core_dw);
      end
   end
   assign core_ready = !slow || tog;
endmodule

// ---- verification/pepc_top_properties.sv ----
// timing checks on the port parity block, ports only
// assumes both resets synchronous on aclk
`timescale 1ns/1ps
module pepc_top_properties (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              sticky_resetn,
   input  wire pepc_pkg::pepc_dw_t link_dw,
   input  wire logic              link_valid,
   input  wire logic              link_ready,
   input  wire pepc_pkg::pepc_dw_t core_dw,
   input  wire logic              core_valid,
   input  wire logic              core_ready,
   input  wire logic              err_msg_valid,
   input  wire pepc_pkg::pepc_sev_t err_msg_sev,
   input  wire logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              s_axi_bvalid,
   input  wire logic              s_axi_bready
);
   import pepc_pkg::*;
   logic bad_take;   // link beat taken with wrong parity
   // even parity per byte, own copy
   function automatic logic [3:0] gp(input logic [31:0] d);
      for (int i = 0; i < 4; i++) gp[i] = ^d[8*i+:8];
   endfunction
   assign bad_take = link_valid && link_ready && (link_dw.par != gp(link_dw.data));
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn || !sticky_resetn);
   a_par_legal: assert property (core_valid |-> (core_dw.par == gp(core_dw.data)) ||
      (core_dw.par == ~gp(core_dw.data))) else $error("core parity neither right nor inverted");
   a_out_hold: assert property (core_valid && !core_ready |=> core_valid && $stable(core_dw))
      else $error("core beat dropped or changed while stalled");
   a_link_fwd: assert property (link_valid && link_ready |=> core_valid &&
      core_dw.data == $past(link_dw.data)) else $error("link beat not forwarded next cycle");
   a_msg_cause: assert property (err_msg_valid |-> $past(bad_take))
      else $error("error message without a bad link beat");
   a_msg_kind: assert property (err_msg_valid |-> err_msg_sev != SEV_NONE)
      else $error("error message of kind none");
   a_msg_pulse: assert property (err_msg_valid |=> !err_msg_valid)
      else $error("error message longer than one cycle");
   a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
   a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answered twice");
endmodule
bind pepc_top pepc_top_properties pepc_top_properties_inst (.aclk(aclk), .aresetn(aresetn),
   .sticky_resetn(sticky_resetn), .link_dw(link_dw), .link_valid(link_valid), .link_ready(link_ready),
   .core_dw(core_dw), .core_valid(core_valid), .core_ready(core_ready), .err_msg_valid(err_msg_valid),
   .err_msg_sev(err_msg_sev), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// ---- verification/pepc_top_tb_top.sv ----
// self-checking bench for the port parity block
// assumes the core model in pepc_core_model.sv and the bound checker
`timescale 1ns/1ps
module pepc_top_tb_top;
   import pepc_pkg::*;
   logic        aclk = 0, aresetn = 0, sticky_resetn = 0, slow = 0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0]  s_axi_wstrb = '0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   pepc_dw_t    link_dw = '0, gen_dw = '0, core_dw;
   logic        link_valid = 0, gen_valid = 0, link_ready, gen_ready, core_valid, core_ready;
   logic        err_msg_valid, irq;
   pepc_sev_t   err_msg_sev;
   int          bad_count = 0, tests_run = 0, msgs = 0;
   logic [1:0]  last_sev = '0;
   always #4 aclk = ~aclk;
   pepc_top pepc_top_inst (.aclk, .aresetn, .sticky_resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .link_dw, .link_valid, .link_ready, .gen_dw, .gen_valid, .gen_ready, .core_dw,
      .core_valid, .core_ready, .err_msg_valid, .err_msg_sev, .irq);
   pepc_core_model pepc_core_model_inst (.aclk, .aresetn, .core_dw, .core_valid, .core_ready, .slow);
   // count error messages as they pulse
   always @(posedge aclk) if (err_msg_valid === 1'b1) begin
      msgs++;
      last_sev = err_msg_sev;
   end
   function automatic logic [3:0] gp(input logic [31:0] d);
      for (int i = 0; i < 4; i++) gp[i] = ^d[8*i+:8];
   endfunction
   task automatic report_and_stop;
      $display("counts: %0d compared, %0d bad", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic tmo;
      bad_count++;
      report_and_stop;
   endtask
   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one write: address and data offered together, bready held until answer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 0;
      if (n == 50) tmo;
      chk(s_axi_bresp, RESP_OKAY);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 0;
      if (n == 50) tmo;
      chk({2'h0, s_axi_rresp, s_axi_rdata}, {2'h0, er, ed});
   endtask
   // one beat from link (g=0) or originated (g=1), then its copy at the core
   task automatic beat(input bit g, input logic [31:0] d, input logic [3:0] p, input bit s, input bit e,
                       input logic [3:0] ep);
      int n;
      pepc_dw_t b;
      b = '{data: d, par: p, sop: s, eop: e};
      @(posedge aclk);
      if (g) begin gen_dw <= b; gen_valid <= 1; end else begin link_dw <= b; link_valid <= 1; end
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (g ? gen_ready : link_ready) break;
      end
      gen_valid <= 0; link_valid <= 0;
      for (int k = 0; k < 50 && pepc_core_model_inst.got.size() == 0; k++) @(posedge aclk);
      if (n == 50 || pepc_core_model_inst.got.size() == 0) tmo;
      b = pepc_core_model_inst.got.pop_front();
      chk({b.data, b.par}, {d, ep});
   endtask
   initial begin
      logic [7:0] hdr;
      repeat (4) @(posedge aclk);
      aresetn <= 1; sticky_resetn <= 1;
      rd(OFF_CTRL, 32'h0, RESP_OKAY);
      rd(OFF_REPCTL, 32'h2, RESP_OKAY);
      rd(12'h7f0, 32'h0, RESP_SLVERR);
      $display("test reset values done");
      beat(0, 32'h12345678, gp(32'h12345678), 1, 1, gp(32'h12345678));
      wr(OFF_IRQ_EN, 32'h1);
      beat(0, 32'h0a0b0c0d, ~gp(32'h0a0b0c0d), 1, 1, gp(32'h0a0b0c0d));
      rd(OFF_STAT, 32'h1, RESP_OKAY);
      chk({msgs[7:0], 26'h0, last_sev}, {8'h1, 28'h2});
      chk(irq, 1'b1);
      wr(OFF_IRQ_CLR, 32'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(OFF_STAT, 32'h1);
      rd(OFF_STAT, 32'h0, RESP_OKAY);
      rd(OFF_TALLY, 32'h1, RESP_OKAY);
      rd(OFF_TALLY, 32'h0, RESP_OKAY);
      $display("test error detect done");
      wr(OFF_CTRL, 32'h1);
      beat(0, 32'h55aa00ff, ~gp(32'h55aa00ff), 1, 1, gp(32'h55aa00ff));
      rd(OFF_STAT, 32'h0, RESP_OKAY);
      rd(OFF_TALLY, 32'h0, RESP_OKAY);
      wr(OFF_CTRL, 32'h0);
      for (int s = 0; s < 4; s++) begin
         wr(OFF_REPCTL, s);
         wr(OFF_STAT, 32'h1);
         hdr = msgs[7:0];
         beat(0, 32'h0f0f0f0f + s, ~gp(32'h0f0f0f0f + s), 1, 1, gp(32'h0f0f0f0f + s));
         @(posedge aclk);
         chk({msgs[7:0] - hdr, 26'h0, last_sev}, {7'h0, s != 0, 26'h0, (s != 0) ? 2'(s) : last_sev});
      end
      rd(OFF_TALLY, 32'h4, RESP_OKAY);
      $display("test report kinds done");
      slow <= 1;
      for (int i = 0; i < 260; i++) beat(0, i, ~gp(i), 1, 1, gp(i));
      slow <= 0;
      rd(OFF_TALLY, 32'hff, RESP_OKAY);
      rd(OFF_TALLY, 32'h0, RESP_OKAY);
      rd(OFF_IRQ_STAT, 32'h3, RESP_OKAY);
      $display("test tally saturation done");
      wr(OFF_CTRL, 32'h5a02);
      for (int t = 0; t < 4; t++) begin
         hdr = t[1] ? 8'h5b : 8'h5a;
         beat(t[0], {hdr, 24'h123456}, gp({hdr, 24'h123456}), 1, 0,
              t[1] ? gp({hdr, 24'h123456}) : ~gp({hdr, 24'h123456}));
         beat(t[0], 32'hcafe0001, gp(32'hcafe0001), 0, 1,
              t[1] ? gp(32'hcafe0001) : ~gp(32'hcafe0001));
      end
      aresetn <= 0;
      @(posedge aclk);
      aresetn <= 1;
      rd(OFF_CTRL, 32'h5a02, RESP_OKAY);
      rd(OFF_REPCTL, 32'h2, RESP_OKAY);
      $display("test inject done");
      report_and_stop;
   end
endmodule
